// ==== flash_por_state.sv ====
module flash_por_state #(
    parameter int unsigned power_up_cycles = flash_por_pkg::first_write_power_up_cycles
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic por_active,
    input wire flash_por_pkg::spi_pins_t pins,
    input wire logic write_request,
    output flash_por_pkg::por_status_t status,
    output logic write_start,
    output logic sdo,
    output logic sdo_oe,
    output logic standby
);
    flash_por_pkg::spi_pins_t meta;
    flash_por_pkg::spi_pins_t sync;
    logic prev_select_n;
    logic por_meta;
    logic por_sync;
    logic [31:0] delay_count;
    logic delay_done;
    logic first_pending;
    flash_por_pkg::por_state_t state;
    logic select_fall;
    logic in_reset;
    logic instr_start;
    logic mode3;
    logic in_transaction;
    logic write_allowed;

    // Every pin goes through two flops; only the second stage feeds logic.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            meta <= '1;
            sync <= '1;
            por_meta <= 1'b1;
            por_sync <= 1'b1;
        end else begin
            meta <= pins;
            sync <= meta;
            por_meta <= por_active;
            por_sync <= por_meta;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            prev_select_n <= 1'b1;
        end else begin
            prev_select_n <= sync.select_n;
        end
    end

    assign in_reset = por_sync;
    assign select_fall = prev_select_n && !sync.select_n;

    // An instruction opens only on a select fall seen while idle in standby.
    function automatic logic fall_accepted(
        input flash_por_pkg::por_state_t cur,
        input logic fall
    );
        return cur == flash_por_pkg::st_standby && fall;
    endfunction

    // Each status field lives in its own flop so that no field has two driving processes.
    assign status = {instr_start, mode3, in_transaction, write_allowed};

    // Reset-time state resolves first; a fall seen during reset is dropped on purpose.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state <= flash_por_pkg::st_reset;
        end else begin
            case (state)
                flash_por_pkg::st_reset: begin
                    if (!in_reset) begin
                        state <= flash_por_pkg::st_standby; // RULE_07
                    end
                end
                flash_por_pkg::st_standby: begin
                    if (in_reset) begin
                        state <= flash_por_pkg::st_reset; // RULE_06
                    end else if (select_fall) begin
                        state <= flash_por_pkg::st_active; // RULE_03
                    end
                end
                flash_por_pkg::st_active: begin
                    if (in_reset) begin
                        state <= flash_por_pkg::st_reset; // RULE_06
                    end else if (sync.select_n) begin
                        state <= flash_por_pkg::st_standby;
                    end
                end
                default: begin
                    state <= flash_por_pkg::st_reset;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n || in_reset) begin
            mode3 <= flash_por_pkg::mode_after_reset; // RULE_01
        end else if (fall_accepted(state, select_fall)) begin
            mode3 <= sync.sclk; // RULE_04 RULE_09
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n || in_reset) begin
            instr_start <= 1'b0;
            in_transaction <= 1'b0;
        end else begin
            instr_start <= fall_accepted(state, select_fall); // RULE_03
            in_transaction <= state == flash_por_pkg::st_active && !sync.select_n;
        end
    end

    // The counter restarts from power-on reset, so the wait covers each power-up.
    always_ff @(posedge sys_clk) begin
        if (!reset_n || in_reset) begin
            delay_count <= 32'h0000_0000;
            delay_done <= 1'b0;
        end else if (!delay_done) begin
            if (delay_count == power_up_cycles - 1) begin
                delay_done <= 1'b1; // RULE_08
            end
            delay_count <= delay_count + 32'h0000_0001;
        end
    end

    // Every program or erase requested between power-on reset release and the delay end is held back; they park as one start until the delay ends.
    always_ff @(posedge sys_clk) begin
        if (!reset_n || in_reset) begin
            first_pending <= 1'b0;
            write_start <= 1'b0;
            write_allowed <= 1'b0;
        end else begin
            write_allowed <= delay_done;
            write_start <= 1'b0;
            if (write_request && !delay_done) begin
                first_pending <= 1'b1;
            end else if (delay_done && (first_pending || write_request)) begin
                write_start <= 1'b1; // RULE_08
                first_pending <= 1'b0;
            end
        end
    end

    // No read path lives here, so the output pin is never driven.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sdo <= 1'b0;
            sdo_oe <= 1'b0; // RULE_02
            standby <= 1'b0;
        end else begin
            sdo <= 1'b0;
            sdo_oe <= 1'b0; // RULE_02
            standby <= state == flash_por_pkg::st_standby; // RULE_07
        end
    end

    // The start check looks at the synchronised pin itself, not at the edge detector.
    a_mode_reset_default: assert property ( // RULE_01
        @(posedge sys_clk) disable iff (!reset_n)
        $past(in_reset) |-> status.mode3)
        else $error("mode not 3 after reset");

    a_output_hiz: assert property ( // RULE_02
        @(posedge sys_clk) disable iff (!reset_n)
        !sdo_oe)
        else $error("serial output driven");

    a_start_needs_fall: assert property ( // RULE_03
        @(posedge sys_clk) disable iff (!reset_n)
        status.instr_start |-> $past(sync.select_n, 2) && !$past(sync.select_n)
            && $past(state) == flash_por_pkg::st_standby)
        else $error("start without select fall");

    a_start_one_cycle: assert property ( // RULE_03
        @(posedge sys_clk) disable iff (!reset_n)
        status.instr_start |=> !status.instr_start)
        else $error("start pulse longer than one cycle");

    a_mode_sampled_clock: assert property ( // RULE_04
        @(posedge sys_clk) disable iff (!reset_n || in_reset)
        status.instr_start |-> status.mode3 == $past(sync.sclk))
        else $error("mode not taken from idle clock");

    a_reset_blocks_cmd: assert property ( // RULE_06
        @(posedge sys_clk) disable iff (!reset_n)
        in_reset |=> !status.instr_start && !write_start)
        else $error("command accepted in reset");

    a_reset_holds_state: assert property ( // RULE_06
        @(posedge sys_clk) disable iff (!reset_n)
        in_reset |=> state == flash_por_pkg::st_reset)
        else $error("state left reset during power-on reset");

    a_standby_after_por: assert property ( // RULE_07
        @(posedge sys_clk) disable iff (!reset_n)
        $fell(in_reset) |-> ##[1:2] standby)
        else $error("no standby after reset release");

    a_standby_not_busy: assert property ( // RULE_07
        @(posedge sys_clk) disable iff (!reset_n)
        standby |-> !status.in_transaction)
        else $error("standby shown during a transaction");

    a_write_waits_delay: assert property ( // RULE_08
        @(posedge sys_clk) disable iff (!reset_n)
        write_start |-> $past(delay_done))
        else $error("write before power-up delay");

    a_write_count_done: assert property ( // RULE_08
        @(posedge sys_clk) disable iff (!reset_n)
        write_start |-> delay_count == power_up_cycles)
        else $error("write before full delay count");

    a_pending_issued: assert property ( // RULE_08
        @(posedge sys_clk) disable iff (!reset_n || in_reset)
        delay_done && first_pending |=> write_start)
        else $error("parked write not issued");

    a_mode_held_frame: assert property ( // RULE_09
        @(posedge sys_clk) disable iff (!reset_n || in_reset)
        (state == flash_por_pkg::st_active && $past(state) == flash_por_pkg::st_active)
        |-> $stable(status.mode3))
        else $error("mode changed mid transaction");

    a_mode_only_on_start: assert property ( // RULE_09
        @(posedge sys_clk) disable iff (!reset_n)
        $changed(status.mode3) |-> status.instr_start || $past(in_reset))
        else $error("mode changed without a new instruction");
endmodule

// ==== flash_por_pkg.sv ====
// Operation
// RULE_01 - After power-up or any reset the interface runs in clock mode 3.
// RULE_02 - After power-up or reset the serial output stays high impedance.
// RULE_03 - An instruction starts only after a chip-select falling edge.
// RULE_04 - Each chip-select fall samples idle clock: high gives mode 3, low mode 0.
// RULE_05 - Host keeps chip select high 70 us after supply is good.
// RULE_06 - While internal power-on reset holds, all commands are ignored.
// RULE_07 - Release of power-on reset puts the device in standby.
// RULE_08 - First program or erase after power-up waits an internal delay of 5 ms.
// RULE_09 - Detected clock mode holds for the whole transaction until the next fall.
package flash_por_pkg;
    localparam int unsigned clk_period_ns = 4;
    localparam int unsigned supply_to_select_wait_us = 70;
    localparam int unsigned first_write_power_up_delay_ms = 5;
    localparam int unsigned first_write_power_up_cycles =
        first_write_power_up_delay_ms * 1000000 / clk_period_ns;
    localparam logic mode_after_reset = 1'b1;

    typedef enum logic [1:0] {
        st_reset,
        st_standby,
        st_active
    } por_state_t;

    typedef struct packed {
        logic select_n;
        logic sclk;
        logic sdi;
    } spi_pins_t;

    typedef struct packed {
        logic instr_start;
        logic mode3;
        logic in_transaction;
        logic write_allowed;
    } por_status_t;
endpackage

// ==== spi_host_model.sv ====
module spi_host_model (
    input wire logic go,
    input wire logic idle_hi,
    output flash_por_pkg::spi_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // The link clock stands still at its idle level outside frames.
    initial pins = 3'b110;
    always @(posedge go) begin
        pins.sclk = idle_hi;
        #20 pins.select_n = 1'b0;
        repeat (8) begin
            #62.5 pins.sclk = ~pins.sclk;
            pins.sdi = ~pins.sdi;
            #62.5 pins.sclk = ~pins.sclk;
        end
        #20 pins.select_n = 1'b1;
        pins.sdi = ~pins.sdi;
    end
endmodule

// ==== testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int sel_wait =
        flash_por_pkg::supply_to_select_wait_us * 1000 / flash_por_pkg::clk_period_ns;
    localparam int pu_cycles = 20;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic por_active = 1'b1;
    logic write_request = 1'b0;
    logic go = 1'b0;
    logic idle_hi = 1'b1;
    flash_por_pkg::spi_pins_t pins;
    flash_por_pkg::por_status_t status;
    logic write_start, sdo, sdo_oe, standby;
    int bad_count = 0;
    int comparisons = 0;
    int starts = 0;
    int n;
    initial forever #2 sys_clk = ~sys_clk;
    spi_host_model host (.go(go), .idle_hi(idle_hi), .pins(pins));
    flash_por_state #(.power_up_cycles(pu_cycles)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .por_active(por_active), .pins(pins), .write_request(write_request),
        .status(status), .write_start(write_start), .sdo(sdo), .sdo_oe(sdo_oe),
        .standby(standby));
    always @(posedge sys_clk) if (status.instr_start === 1'b1) starts++;
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (exp !== got) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task test_done;
        if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Runs one frame; checks the mode in mid-frame when the clock is away from idle.
    task frame(input logic hi, input logic exp_mode, input logic exp_busy);
        int k;
        @(posedge sys_clk) idle_hi <= hi;
        go <= 1'b1;
        @(posedge sys_clk) go <= 1'b0;
        for (k = 0; k < 100 && pins.select_n !== 1'b0; k++) @(posedge sys_clk);
        chk("host select fall", 0, pins.select_n);
        for (k = 0; k < 100 && pins.sclk === hi; k++) @(posedge sys_clk);
        repeat (4) @(posedge sys_clk);
        chk("mode3 mid frame", exp_mode, status.mode3);
        chk("in_transaction mid frame", exp_busy, status.in_transaction);
        for (k = 0; k < 400 && pins.select_n !== 1'b1; k++) @(posedge sys_clk);
        chk("host select rise", 1, pins.select_n);
        repeat (4) @(posedge sys_clk);
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        chk("mode3 after reset", 1, status.mode3);
        chk("sdo_oe after reset", 0, sdo_oe);
        frame(1'b0, 1'b1, 1'b0);
        chk("starts during por", 0, starts);
        chk("standby during por", 0, standby);
        chk("write_allowed during por", 0, status.write_allowed);
        // A request during power-on reset is dropped, so it is raised after release.
        por_active <= 1'b0;
        repeat (5) @(posedge sys_clk);
        write_request <= 1'b1;
        @(posedge sys_clk) write_request <= 1'b0;
        for (n = 6; n < 100 && write_start !== 1'b1; n++) @(posedge sys_clk);
        chk("first write delay", 1, n >= pu_cycles && n <= pu_cycles + 6);
        chk("write_allowed after delay", 1, status.write_allowed);
        chk("standby after por", 1, standby);
        write_request <= 1'b1;
        @(posedge sys_clk) write_request <= 1'b0;
        @(posedge sys_clk);
        chk("later write passes", 1, write_start);
        repeat (sel_wait) @(posedge sys_clk);
        frame(1'b0, 1'b0, 1'b1);
        chk("starts mode0 frame", 1, starts);
        frame(1'b1, 1'b1, 1'b1);
        chk("starts mode3 frame", 2, starts);
        chk("sdo_oe in use", 0, sdo_oe);
        frame(1'b0, 1'b0, 1'b1);
        chk("starts third frame", 3, starts);
        @(posedge sys_clk) reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        chk("mode3 after second reset", 1, status.mode3);
        chk("standby in second reset", 0, standby);
        repeat (4) @(posedge sys_clk);
        chk("standby after second reset", 1, standby);
        chk("sdo_oe after second reset", 0, sdo_oe);
        test_done();
    end
    initial begin
        #200000;
        bad_count++;
        test_done();
    end
endmodule
